// File: shared/srcf_pkg.sv
package srcf_pkg;

  // register map of the serial port (7-bit address, 8-bit data)
  localparam logic [6:0] ADDR_SR_DELAY  = 7'h60;
  localparam logic [6:0] ADDR_UNLOCK    = 7'h61;
  localparam logic [6:0] ADDR_PULSE_CNT = 7'h62;
  localparam logic [6:0] ADDR_CTRL      = 7'h63;
  localparam logic [6:0] ADDR_VCXO_CFG  = 7'h64;

  // reset values and the unlock code
  localparam logic [7:0] RST_SR_DELAY  = 8'h00;
  localparam logic [7:0] RST_UNLOCK    = 8'h00;
  localparam logic [7:0] RST_PULSE_CNT = 8'h02;
  localparam logic [7:0] UNLOCK_CODE   = 8'h4B;

  // bit positions inside the control register
  localparam int CTRL_INSEL  = 0;
  localparam int CTRL_SRCSEL = 1;
  localparam int CTRL_MODE   = 2;
  localparam int CTRL_MASK   = 3;
  localparam int CTRL_WIRE   = 4;
  localparam int CTRL_LVL0   = 5;
  localparam int CTRL_LVL1   = 6;
  localparam int CTRL_TRIG   = 7;

  // vcxo output startup setting: lvpecl, 750 mV, powered on
  localparam logic       STYLE_LVPECL = 1'b0;
  localparam logic [1:0] AMP_750MV    = 2'h1;
  localparam logic       PWR_ON       = 1'b1;

  // serial frame: read flag, 7 address bits, 8 data bits
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] ADDR_DONE  = 5'h08;
  localparam logic [4:0] CNT_ZERO   = 5'h00;
  localparam logic [4:0] CNT_ONE    = 5'h01;

  // timing
  localparam int DELAY_STEP_PS    = 509;
  localparam int CLK_PERIOD_PS    = 10000;
  localparam int SYSREF_PERIOD_NS = 80;
  localparam int HALF_CYC_INT     = (SYSREF_PERIOD_NS * 1000) / CLK_PERIOD_PS / 2;
  localparam logic [7:0] HALF_CYC_LAST = 8'(HALF_CYC_INT - 1);
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [7:0] BYTE_ONE      = 8'h01;

  typedef struct packed {
    logic lvl1;
    logic lvl0;
    logic wire_mode;
    logic mask;
    logic mode;
    logic srcsel;
    logic insel;
  } srcf_ctrl_t;

  typedef struct packed {
    logic       pd_n;
    logic       style;
    logic [1:0] amp;
  } srcf_vcxo_t;

  localparam srcf_vcxo_t VCXO_STARTUP = '{pd_n: PWR_ON, style: STYLE_LVPECL, amp: AMP_750MV};
  localparam srcf_ctrl_t CTRL_RESET   = '0;

  typedef enum logic [1:0] {G_IDLE, G_HIGH, G_LOW} srcf_gen_t;

endpackage : srcf_pkg

// File: logic/srcf_pulse_gen.sv
`timescale 1ns/1ps
module srcf_pulse_gen
  import srcf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire srcf_ctrl_t ctrl,
  input  wire logic [7:0] count,
  input  wire logic       ext_pin,
  input  wire logic       alt_in,
  output logic            sysref_reg,
  output logic            power_reg
);

  srcf_gen_t  state_reg, state_next;
  logic [7:0] tmr_reg, tmr_next;
  logic [7:0] left_reg, left_next;
  logic [7:0] seen_reg;

  wire sel_in   = ctrl.insel ? alt_in : ext_pin;
  wire tmr_done = (tmr_reg == BYTE_ZERO);
  wire stop     = ctrl.srcsel | (~ctrl.mode & (left_reg == BYTE_ZERO));
  wire go       = start & ~ctrl.srcsel & (ctrl.mode | (count != BYTE_ZERO));

  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_done ? tmr_reg : tmr_reg - BYTE_ONE;
    left_next  = left_reg;
    if (go) begin
      state_next = G_HIGH;
      tmr_next   = HALF_CYC_LAST;
      left_next  = count;
    end else begin
      case (state_reg)
        G_HIGH: if (tmr_done) begin
          state_next = G_LOW;
          tmr_next   = HALF_CYC_LAST;
          if (!ctrl.mode) left_next = left_reg - BYTE_ONE;
        end
        G_LOW: if (tmr_done) begin
          state_next = stop ? G_IDLE : G_HIGH;
          tmr_next   = HALF_CYC_LAST;
        end
        default: state_next = G_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg  <= G_IDLE;
      tmr_reg    <= BYTE_ZERO;
      left_reg   <= BYTE_ZERO;
      sysref_reg <= 1'b0;
      power_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      tmr_reg    <= tmr_next;
      left_reg   <= left_next;
      sysref_reg <= ctrl.srcsel ? sel_in : (state_next == G_HIGH);
      power_reg  <= ctrl.srcsel | (state_next != G_IDLE);
    end
  end

  // pulses started after the first one since the last launch, for checking only
  always_ff @(posedge clk) begin
    if (rst || go) seen_reg <= BYTE_ZERO;
    else if (state_reg == G_LOW && state_next == G_HIGH) seen_reg <= seen_reg + BYTE_ONE;
  end

  a_count_bound: assert property (@(posedge clk) disable iff (rst)
    (!ctrl.mode && !ctrl.srcsel && state_reg != G_IDLE)
      |-> (seen_reg < count))
    else $error("counted burst exceeded pulse count");

  a_counted_ends: assert property (@(posedge clk) disable iff (rst)
    (state_reg == G_LOW && tmr_done && !ctrl.mode && !ctrl.srcsel && left_reg == BYTE_ZERO
      && !go) |=> state_reg == G_IDLE ##1 !sysref_reg)
    else $error("counted burst did not stop");

  a_cont_runs: assert property (@(posedge clk) disable iff (rst)
    (state_reg == G_LOW && tmr_done && ctrl.mode && !ctrl.srcsel && !go)
      |=> state_reg == G_HIGH)
    else $error("continuous mode stopped");

  c_counted: cover property (@(posedge clk) disable iff (rst)
    go && !ctrl.mode ##[1:400] state_reg == G_IDLE);

endmodule : srcf_pulse_gen

// File: logic/srcf_top.sv
`timescale 1ns/1ps
// Function
// - global delay code steps sysref outputs 509ps
// - without code 0x4B vcxo output stays startup
// - input select: pin when 0, third input
// - source select: trigger bit or external pin
// - pulse mode: counted bursts or continuous
// - lock mask keeps vcxo lock off pin
// - wire mode: 3-wire shared data, 4-wire output
// - trigger powers up and releases pulses
// - trigger ignored when external source selected
// - trigger aligns outputs and applies delay
// - counted burst gives 1 to 255 pulses
module srcf_top
  import srcf_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  input  wire logic       SPI_SCLK,
  input  wire logic       SPI_CS_N,
  input  wire logic       SERIAL_DATA_SENSE,
  output logic            SERIAL_DATA_DRIVE,
  output logic            SERIAL_DATA_OE,
  output logic            SERIAL_OUT_DRIVE,
  output logic            SERIAL_OUT_OE,
  input  wire logic       EXT_SYSREF_PIN,
  input  wire logic       SYSREF_ALT_IN,
  input  wire logic       VCXO_PLL_LOCK_LOSS,
  input  wire logic       SYNTH_PLL_LOCK_LOSS,
  output logic            SYSREF_OUT,
  output logic            SYSREF_POWER_UP,
  output logic            SYSREF_ALIGN,
  output logic [7:0]      SYSREF_DELAY_CODE,
  output logic            VCXO_OUT_POWER_DOWN_N,
  output logic            VCXO_OUT_STYLE,
  output logic [1:0]      VCXO_OUT_AMPLITUDE,
  output logic            SERIAL_IO_LEVEL_3V3,
  output logic            STATUS_IO_LEVEL_3V3,
  output logic            LOCK_OUT
);

  // configuration registers
  logic [7:0] global_sysref_delay_reg;
  logic [7:0] vcxo_out_mod_unlock_reg;
  logic [7:0] sysref_pulse_count_reg;
  srcf_ctrl_t ctrl_reg;
  srcf_vcxo_t vcxo_cfg_reg;
  logic       sysref_trigger_reg;

  // serial port state
  logic        sclk_prev_reg;
  logic [4:0]  bit_cnt_reg;
  logic [14:0] shift_in_reg;
  logic [7:0]  tx_reg;
  logic        rd_phase_reg;

  // serial edges; pins are synchronous to the system clock
  wire sclk_rise = SPI_SCLK & ~sclk_prev_reg & ~SPI_CS_N;
  wire sclk_fall = ~SPI_SCLK & sclk_prev_reg & ~SPI_CS_N;

  wire       frame_rd = shift_in_reg[7];
  wire [6:0] rd_addr  = shift_in_reg[6:0];
  wire       wr_en    = sclk_rise & (bit_cnt_reg == FRAME_LAST) & ~shift_in_reg[14];
  wire [6:0] wr_addr  = shift_in_reg[13:7];
  wire [7:0] wr_data  = {shift_in_reg[6:0], SERIAL_DATA_SENSE};

  wire wr_delay  = wr_en & (wr_addr == ADDR_SR_DELAY);
  wire wr_unlock = wr_en & (wr_addr == ADDR_UNLOCK);
  wire wr_count  = wr_en & (wr_addr == ADDR_PULSE_CNT);
  wire wr_ctrl   = wr_en & (wr_addr == ADDR_CTRL);
  wire wr_vcxo   = wr_en & (wr_addr == ADDR_VCXO_CFG);

  wire [7:0] ctrl_rd = {sysref_trigger_reg, ctrl_reg};
  wire [7:0] vcxo_rd = {4'h0, vcxo_cfg_reg};

  // read mux; unmapped addresses read as zero
  wire [7:0] rd_data =
    (rd_addr == ADDR_SR_DELAY)  ? global_sysref_delay_reg :
    (rd_addr == ADDR_UNLOCK)    ? vcxo_out_mod_unlock_reg :
    (rd_addr == ADDR_PULSE_CNT) ? sysref_pulse_count_reg  :
    (rd_addr == ADDR_CTRL)      ? ctrl_rd                 :
    (rd_addr == ADDR_VCXO_CFG)  ? vcxo_rd                 : BYTE_ZERO;

  // trigger: only honoured with the internal source selected
  wire trig_req = wr_ctrl & wr_data[CTRL_TRIG] & ~wr_data[CTRL_SRCSEL];
  wire launch   = sysref_trigger_reg & ~ctrl_reg.srcsel;

  wire        unlocked = (vcxo_out_mod_unlock_reg == UNLOCK_CODE);
  srcf_vcxo_t vcxo_eff;
  assign vcxo_eff = unlocked ? vcxo_cfg_reg : VCXO_STARTUP;

  wire lock_loss = SYNTH_PLL_LOCK_LOSS | (VCXO_PLL_LOCK_LOSS & ~ctrl_reg.mask);

  wire       rd_start  = sclk_fall & (bit_cnt_reg == ADDR_DONE) & frame_rd;
  wire       rd_shift  = sclk_fall & rd_phase_reg;
  wire [7:0] tx_next   = rd_start ? rd_data : {tx_reg[6:0], 1'b0};
  wire       rd_active = rd_phase_reg | rd_start;

  // serial shift logic
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sclk_prev_reg <= 1'b0;
      bit_cnt_reg   <= CNT_ZERO;
      shift_in_reg  <= '0;
      tx_reg        <= BYTE_ZERO;
      rd_phase_reg  <= 1'b0;
    end else begin
      sclk_prev_reg <= SPI_SCLK;
      if (SPI_CS_N) begin
        bit_cnt_reg  <= CNT_ZERO;
        rd_phase_reg <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_in_reg <= {shift_in_reg[13:0], SERIAL_DATA_SENSE};
          bit_cnt_reg  <= bit_cnt_reg + CNT_ONE;
        end
        if (rd_start || rd_shift) tx_reg <= tx_next;
        if (rd_start) rd_phase_reg <= 1'b1;
        else if (sclk_rise && bit_cnt_reg == FRAME_LAST) rd_phase_reg <= 1'b0;
      end
    end
  end

  // serial pin drivers; in 3-wire mode the output pin never drives
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      SERIAL_DATA_DRIVE <= 1'b0;
      SERIAL_DATA_OE    <= 1'b0;
      SERIAL_OUT_DRIVE  <= 1'b0;
      SERIAL_OUT_OE     <= 1'b0;
    end else begin
      if (rd_start || rd_shift) begin
        SERIAL_DATA_DRIVE <= tx_next[7];
        SERIAL_OUT_DRIVE  <= tx_next[7];
      end
      SERIAL_DATA_OE <= ~ctrl_reg.wire_mode & rd_active & ~SPI_CS_N;
      SERIAL_OUT_OE  <= ctrl_reg.wire_mode & ~SPI_CS_N;
    end
  end

  // configuration writes
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      global_sysref_delay_reg <= RST_SR_DELAY;
      vcxo_out_mod_unlock_reg <= RST_UNLOCK;
      sysref_pulse_count_reg  <= RST_PULSE_CNT;
      ctrl_reg                <= CTRL_RESET;
      vcxo_cfg_reg            <= VCXO_STARTUP;
    end else begin
      if (wr_delay) global_sysref_delay_reg <= wr_data;
      if (wr_unlock) vcxo_out_mod_unlock_reg <= wr_data;
      if (wr_count) sysref_pulse_count_reg <= wr_data;
      if (wr_ctrl) ctrl_reg <= wr_data[6:0];
      if (wr_vcxo) vcxo_cfg_reg <= wr_data[3:0]; // held while locked, applied at unlock
    end
  end

  // self-clearing trigger; a new request wins over the clear
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) sysref_trigger_reg <= 1'b0;
    else if (trig_req) sysref_trigger_reg <= 1'b1;
    else if (launch) sysref_trigger_reg <= 1'b0;
  end

  // alignment and delay take effect only at launch
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      SYSREF_ALIGN      <= 1'b0;
      SYSREF_DELAY_CODE <= RST_SR_DELAY;
    end else begin
      SYSREF_ALIGN <= launch;
      if (launch) SYSREF_DELAY_CODE <= global_sysref_delay_reg;
    end
  end

  // outputs steered by the configuration fields
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      VCXO_OUT_POWER_DOWN_N <= PWR_ON;
      VCXO_OUT_STYLE        <= STYLE_LVPECL;
      VCXO_OUT_AMPLITUDE    <= AMP_750MV;
      SERIAL_IO_LEVEL_3V3   <= 1'b0;
      STATUS_IO_LEVEL_3V3   <= 1'b0;
      LOCK_OUT              <= 1'b0;
    end else begin
      VCXO_OUT_POWER_DOWN_N <= vcxo_eff.pd_n;
      VCXO_OUT_STYLE        <= vcxo_eff.style;
      VCXO_OUT_AMPLITUDE    <= vcxo_eff.amp;
      SERIAL_IO_LEVEL_3V3   <= ctrl_reg.lvl0;
      STATUS_IO_LEVEL_3V3   <= ctrl_reg.lvl1;
      LOCK_OUT              <= ~lock_loss;
    end
  end

  srcf_pulse_gen srcf_pulse_gen_i (
    .clk        (CLK_SYS),
    .rst        (SYS_RST),
    .start      (launch),
    .ctrl       (ctrl_reg),
    .count      (sysref_pulse_count_reg),
    .ext_pin    (EXT_SYSREF_PIN),
    .alt_in     (SYSREF_ALT_IN),
    .sysref_reg (SYSREF_OUT),
    .power_reg  (SYSREF_POWER_UP)
  );

  // checks
  a_delay_apply: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    launch && !wr_delay |=> SYSREF_DELAY_CODE == $past(global_sysref_delay_reg) && SYSREF_ALIGN)
    else $error("delay code not applied at launch");

  a_vcxo_startup: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (vcxo_out_mod_unlock_reg != UNLOCK_CODE) |=> VCXO_OUT_POWER_DOWN_N == PWR_ON
      && VCXO_OUT_STYLE == STYLE_LVPECL && VCXO_OUT_AMPLITUDE == AMP_750MV)
    else $error("vcxo output left startup while locked");

  a_input_select: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ctrl_reg.srcsel |=> SYSREF_OUT == ($past(ctrl_reg.insel) ? $past(SYSREF_ALT_IN)
      : $past(EXT_SYSREF_PIN)))
    else $error("external sysref path wrong input");

  a_trig_ignored: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ctrl_reg.srcsel && !trig_req |=> !sysref_trigger_reg ##1 !SYSREF_ALIGN)
    else $error("trigger acted under external source");

  a_trig_power: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    launch && sysref_pulse_count_reg != BYTE_ZERO |-> ##2 SYSREF_POWER_UP && SYSREF_OUT)
    else $error("trigger did not release pulses");

  a_trig_selfclr: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    sysref_trigger_reg && !trig_req |=> !sysref_trigger_reg)
    else $error("trigger bit did not clear");

  a_lock_mask: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !SYS_RST && !SYNTH_PLL_LOCK_LOSS && (ctrl_reg.mask || !VCXO_PLL_LOCK_LOSS) |=> LOCK_OUT)
    else $error("masked vcxo lock loss reached lock pin");

  a_outpin_hiz: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !$past(ctrl_reg.wire_mode) |-> !SERIAL_OUT_OE)
    else $error("output pin driven in 3-wire mode");

  c_unlock: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    wr_vcxo ##[1:200] wr_unlock && wr_data == UNLOCK_CODE);

  c_continuous: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    launch && ctrl_reg.mode ##[20:60] SYSREF_OUT);

  c_read4: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
    rd_start && ctrl_reg.wire_mode);

endmodule : srcf_top

// File: tb/srcf_spi_host.sv
`timescale 1ns/1ps
module srcf_spi_host (
  input  wire logic clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  output logic      mosi_oe
);
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    mosi    = 1'b0;
    mosi_oe = 1'b0;
  end

  // mode 0, three system cycles per half period so every edge is seen
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wd,
                      output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {rd, adr, wd};
    rdat  = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      sclk    <= 1'b0;
      mosi    <= frame[15-i];
      mosi_oe <= !(rd && i >= 8);
      repeat (3) @(posedge clk);
      if (i >= 8) rdat[15-i] = miso;
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    sclk    <= 1'b0;
    cs_n    <= 1'b1;
    mosi_oe <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : xfer
endmodule : srcf_spi_host

// File: tb/test_srcf_top.sv
`timescale 1ns/1ps
module test_srcf_top
  import srcf_pkg::*;
();
  logic       clk_sys, sys_rst, ext_pin, alt_in, vcxo_loss, synth_loss, wire4;
  logic       sclk, cs_n, mosi, mosi_oe, data_drive, data_oe, out_drive, out_oe;
  logic       sysref_out, sysref_power_up, sysref_align, vcxo_pd_n, vcxo_style;
  logic       serial_lvl, status_lvl, lock_out, prev_out;
  logic [7:0] sysref_delay_code;
  logic [1:0] vcxo_amp;
  int         err_total, samples_checked, rises, aligns;
  // a released data line shows the inverse of its last value, never a held copy
  wire logic       data_sense = data_oe ? data_drive : (mosi_oe ? mosi : ~mosi);
  wire logic       miso       = wire4 ? (out_oe ? out_drive : ~out_drive) : data_sense;
  wire logic [3:0] vcxo_seen = {vcxo_pd_n, vcxo_style, vcxo_amp};

  srcf_top srcf_top_i (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SPI_SCLK(sclk),
    .SPI_CS_N(cs_n), .SERIAL_DATA_SENSE(data_sense), .SERIAL_DATA_DRIVE(data_drive),
    .SERIAL_DATA_OE(data_oe), .SERIAL_OUT_DRIVE(out_drive), .SERIAL_OUT_OE(out_oe),
    .EXT_SYSREF_PIN(ext_pin), .SYSREF_ALT_IN(alt_in),
    .VCXO_PLL_LOCK_LOSS(vcxo_loss), .SYNTH_PLL_LOCK_LOSS(synth_loss),
    .SYSREF_OUT(sysref_out), .SYSREF_POWER_UP(sysref_power_up), .SYSREF_ALIGN(sysref_align),
    .SYSREF_DELAY_CODE(sysref_delay_code), .VCXO_OUT_POWER_DOWN_N(vcxo_pd_n),
    .VCXO_OUT_STYLE(vcxo_style), .VCXO_OUT_AMPLITUDE(vcxo_amp),
    .SERIAL_IO_LEVEL_3V3(serial_lvl), .STATUS_IO_LEVEL_3V3(status_lvl), .LOCK_OUT(lock_out));

  srcf_spi_host srcf_spi_host_i (.clk(clk_sys), .miso(miso), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .mosi_oe(mosi_oe));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    srcf_spi_host_i.xfer(1'b0, a, d, unused);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] got;
    srcf_spi_host_i.xfer(1'b1, a, 8'h00, got);
    check(got, exp);
  endtask : rd_chk

  task automatic t_reset;
    rd_chk(ADDR_SR_DELAY, RST_SR_DELAY);
    rd_chk(ADDR_UNLOCK, RST_UNLOCK);
    rd_chk(ADDR_PULSE_CNT, RST_PULSE_CNT);
    rd_chk(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_VCXO_CFG, {4'h0, VCXO_STARTUP});
    rd_chk(7'h70, 8'h00);
    check(sysref_out, 1'b0);
  endtask : t_reset

  task automatic t_vcxo;
    wr(ADDR_VCXO_CFG, 8'h04);
    check(vcxo_seen, VCXO_STARTUP);
    wr(ADDR_UNLOCK, UNLOCK_CODE);
    check(vcxo_seen, 8'h04);
    wr(ADDR_UNLOCK, 8'h4A);
    check(vcxo_seen, VCXO_STARTUP);
    rd_chk(ADDR_VCXO_CFG, 8'h04);
  endtask : t_vcxo

  task automatic t_burst(input logic [7:0] n);
    wr(ADDR_SR_DELAY, 8'hFF);
    wr(ADDR_PULSE_CNT, n);
    rises  = 0;
    aligns = 0;
    wr(ADDR_CTRL, 8'h80);
    @(negedge clk_sys);
    check(sysref_power_up, 1'b1);
    repeat (8 * n + 20) @(posedge clk_sys);
    check(8'(rises), n);
    check(8'(aligns), 8'h01);
    check(sysref_delay_code, 8'hFF);
    rd_chk(ADDR_CTRL, 8'h00);
  endtask : t_burst

  task automatic t_cont;
    wr(ADDR_CTRL, 8'h84);
    rises = 0;
    repeat (100) @(posedge clk_sys);
    check(rises > 10, 1'b1);
    wr(ADDR_CTRL, 8'h02);
    rises = 0;
    repeat (40) @(posedge clk_sys);
    check(8'(rises), 8'h00);
  endtask : t_cont

  task automatic t_ext;
    aligns = 0;
    wr(ADDR_CTRL, 8'h82);
    repeat (30) @(posedge clk_sys);
    check(8'(aligns), 8'h00);
    ext_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(sysref_out, 1'b1);
    check(sysref_power_up, 1'b1);
    wr(ADDR_CTRL, 8'h03);
    check(sysref_out, 1'b0);
    alt_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(sysref_out, 1'b1);
    ext_pin <= 1'b0;
    alt_in  <= 1'b0;
  endtask : t_ext

  task automatic t_lock;
    vcxo_loss <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(lock_out, 1'b0);
    wr(ADDR_CTRL, 8'h08);
    check(lock_out, 1'b1);
    synth_loss <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(lock_out, 1'b0);
    vcxo_loss  <= 1'b0;
    synth_loss <= 1'b0;
  endtask : t_lock

  task automatic t_wire;
    wire4 = 1'b1;
    wr(ADDR_CTRL, 8'h70);
    rd_chk(ADDR_SR_DELAY, 8'hFF);
    check(serial_lvl, 1'b1);
    check(status_lvl, 1'b1);
  endtask : t_wire

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // settled values only: edge-launched updates have landed by the falling edge
  always @(negedge clk_sys) begin
    if (sysref_out === 1'b1 && prev_out === 1'b0) rises++;
    if (sysref_align === 1'b1) aligns++;
    prev_out = sysref_out;
    if (!sys_rst) check(wire4 ? data_oe : out_oe, 1'b0);
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    sys_rst    = 1'b1;
    ext_pin    = 1'b0;
    alt_in     = 1'b0;
    vcxo_loss  = 1'b0;
    synth_loss = 1'b0;
    wire4      = 1'b0;
    prev_out   = 1'b0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_vcxo;
    t_burst(8'h01);
    t_burst(8'hFF);
    t_cont;
    t_ext;
    t_lock;
    t_wire;
    conclude;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    conclude;
  end
endmodule : test_srcf_top
